/* common/xdci_regs.svh */
// Timing and reset constants for the X.21 line-side circuit block
`ifndef XDCI_REGS_SVH
`define XDCI_REGS_SVH
`define XDCI_CLK_PERIOD_NS   4
`define XDCI_ES_HALF_NS      64
`define XDCI_ES_HALF_CYC     (((`XDCI_ES_HALF_NS) + (`XDCI_CLK_PERIOD_NS) - 1) / (`XDCI_CLK_PERIOD_NS))
`define XDCI_CTRL_RESET      1'b1
`define XDCI_TXD_RESET       1'b1
`define XDCI_DIV_W           8
`endif

/* common/xdci_pkg.sv */
// Types shared by the X.21 line-side circuit block
package xdci_pkg;
    // Line pins toward the DCE
    typedef struct packed {
        logic transmit;
        logic control;
        logic extTiming;
        logic extTimingOe;
    } xdci_line_out_type;
    // Line pins from the DCE
    typedef struct packed {
        logic receive;
        logic indication;
        logic timing;
        logic cablePresentSense;
    } xdci_line_in_type;
    // Interface select result
    typedef enum logic [1:0] {
        XDCI_IF_EIA = 2'b01,
        XDCI_IF_X21 = 2'b10
    } xdci_if_type;
endpackage : xdci_pkg

/* logic/xdci_dte_line.sv */
// X.21 DTE line-side circuits: T, R, C, I, S, ES and cable sensing
// Overview of operation
// R1: Outgoing user data is shifted onto the transmit circuit toward the DCE.
// R2: Call-control bits from the user use the same transmit circuit path.
// R3: The DCE delivers data and call information on the receive circuit.
// R4: The control circuit follows the block's own interface state changes.
// R5: The DCE reports its state on indication, which the block tracks.
// R6: Transmit changes only at off-to-on transitions of the timing circuit.
// R7: The DCE changes receive only at off-to-on transitions of timing.
// R8: Transmit and receive are sampled at on-to-off transitions of timing.
// R9: In diagnostic test the block drives external timing to a loopback plug.
// R10: Cable strap is sensed at reset, open-channel and parameter-write.
// R11: The latest sensing picks X.21 if the strap is seen, else EIA.
`timescale 1ns/1ps
`include "xdci_regs.svh"
module xdci_dte_line
(
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    // Line side
    input  wire xdci_pkg::xdci_line_in_type lineIn,
    output xdci_pkg::xdci_line_out_type     lineOut,
    // User transmit side
    input  wire logic                       txBit,
    input  wire logic                       controlState,
    input  wire logic                       diagTest,
    output logic                            txTaken,
    // User receive side
    output logic                            rxBit,
    output logic                            rxValid,
    output logic                            indicationState,
    output logic                            indicationChange,
    // Cable sensing
    input  wire logic                       openCmd,
    input  wire logic                       paramWriteCmd,
    output xdci_pkg::xdci_if_type           ifSelect
);
    // Synchronisers for the four line inputs
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic       timPrev_r;
    logic [2:0] resetSense_r;
    logic       transmit_r;
    logic       control_r;
    logic       extTiming_r;
    logic       extTimingOe_r;
    logic [`XDCI_DIV_W-1:0] esCnt_r;
    logic       esClk_r;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end
        else
        begin
            sync1_r <= lineIn;
            sync2_r <= sync1_r;
        end
    end
    // Named views of the synchronised inputs
    wire rxS    = sync2_r[3];
    wire indS   = sync2_r[2];
    wire timS   = sync2_r[1];
    wire cableS = sync2_r[0];
    wire timRise = timS & ~timPrev_r;
    wire timFall = ~timS & timPrev_r;
    wire senseNow = resetSense_r[0] | openCmd | paramWriteCmd;
    wire esWrap = (esCnt_r == `XDCI_DIV_W'(`XDCI_ES_HALF_CYC - 1));
    // Line outputs gathered from their own flip-flops, one driver each
    assign lineOut = {transmit_r, control_r, extTiming_r, extTimingOe_r};
    // Edge history for timing; matches the idle off level of the pin
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            timPrev_r <= 1'b0;
        else
            timPrev_r <= timS;
    end
    // Transmit and control drive, element boundaries on timing rise
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            transmit_r       <= `XDCI_TXD_RESET;
            control_r        <= `XDCI_CTRL_RESET;
            txTaken          <= 1'b0;
        end
        else
        begin
            txTaken <= timRise;                // R1
            if (timRise)
            begin
                transmit_r <= txBit;           // R6 R2
                control_r  <= controlState;    // R4
            end
        end
    end
    // Receive sampling on timing fall and indication tracking
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rxBit            <= 1'b1;
            rxValid          <= 1'b0;
            indicationState  <= 1'b1;
            indicationChange <= 1'b0;
        end
        else
        begin
            rxValid <= timFall;                // R8
            if (timFall)
                rxBit <= rxS;                  // R8 R3 R7
            if (timFall)
                indicationState <= indS;       // R5
            indicationChange <= timFall & (indS != indicationState); // R5
        end
    end
    // External timing divider for loopback diagnostics
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !diagTest)
        begin
            esCnt_r <= '0;
            esClk_r <= 1'b0;
        end
        else
        begin
            esCnt_r <= esWrap ? '0 : esCnt_r + 1'b1;
            if (esWrap)
                esClk_r <= ~esClk_r;           // R9
        end
    end
    // Output and output enable registers for external timing
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            extTiming_r   <= 1'b0;
            extTimingOe_r <= 1'b0;
        end
        else
        begin
            extTiming_r   <= esClk_r;          // R9
            extTimingOe_r <= diagTest;         // R9
        end
    end
    // Cable strap sensing and interface selection
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            resetSense_r <= 3'h4;              // Wait for strap to cross sync
            ifSelect     <= xdci_pkg::XDCI_IF_EIA;
        end
        else
        begin
            resetSense_r <= {1'b0, resetSense_r[2:1]}; // R10
            if (senseNow)                      // R10
                ifSelect <= cableS ? xdci_pkg::XDCI_IF_X21
                                   : xdci_pkg::XDCI_IF_EIA; // R11
        end
    end

    // Assertions
    property p_tx_only_on_rise;
        @(posedge clk_sys) disable iff (!rst_n)
        $changed(lineOut.transmit) |-> $past(timRise);
    endproperty
    a_tx_only_on_rise: assert property (p_tx_only_on_rise) // R6
        else $error("transmit changed without timing rise");
    property p_tx_follows;
        @(posedge clk_sys) disable iff (!rst_n)
        timRise |=> lineOut.transmit == $past(txBit);
    endproperty
    a_tx_follows: assert property (p_tx_follows) // R1
        else $error("transmit not loaded from user bit");
    property p_ctrl_follows;
        @(posedge clk_sys) disable iff (!rst_n)
        timRise |=> lineOut.control == $past(controlState);
    endproperty
    a_ctrl_follows: assert property (p_ctrl_follows) // R4
        else $error("control not loaded");
    sequence s_fall;
        timFall;
    endsequence
    property p_rx_sample;
        @(posedge clk_sys) disable iff (!rst_n)
        s_fall |=> rxValid && rxBit == $past(rxS);
    endproperty
    a_rx_sample: assert property (p_rx_sample) // R8
        else $error("receive not sampled on timing fall");
    property p_rx_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !timFall |=> $stable(rxBit) && !rxValid;
    endproperty
    a_rx_hold: assert property (p_rx_hold) // R8
        else $error("receive changed away from timing fall");
    property p_ind_track;
        @(posedge clk_sys) disable iff (!rst_n)
        timFall |=> indicationState == $past(indS);
    endproperty
    a_ind_track: assert property (p_ind_track) // R5
        else $error("indication not tracked");
    property p_es_oe;
        @(posedge clk_sys) disable iff (!rst_n)
        diagTest |=> lineOut.extTimingOe;
    endproperty
    a_es_oe: assert property (p_es_oe) // R9
        else $error("external timing not enabled in test");
    property p_sense;
        @(posedge clk_sys) disable iff (!rst_n)
        (openCmd || paramWriteCmd) |=>
            ifSelect == ($past(cableS) ? xdci_pkg::XDCI_IF_X21
                                       : xdci_pkg::XDCI_IF_EIA);
    endproperty
    a_sense: assert property (p_sense) // R10
        else $error("strap not sensed on command");
    property p_sel_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !senseNow |=> $stable(ifSelect);
    endproperty
    a_sel_hold: assert property (p_sel_hold) // R11
        else $error("interface select changed without sensing");
    property p_reset_sense;
        @(posedge clk_sys) disable iff (!rst_n)
        resetSense_r[0] |=>
            ifSelect == ($past(cableS) ? xdci_pkg::XDCI_IF_X21
                                       : xdci_pkg::XDCI_IF_EIA);
    endproperty
    a_reset_sense: assert property (p_reset_sense) // R10
        else $error("strap not sensed after reset");
endmodule : xdci_dte_line

/* tb/xdci_dce_model.sv */
// DCE partner model: timing source, R and I driver, T sampler
`timescale 1ns/1ps
module xdci_dce_model
(
    // Bench control
    input  wire logic run,
    input  wire logic rNext,
    input  wire logic iNext,
    // Line
    input  wire logic tPin,
    output logic      sPin,
    output logic      rPin,
    output logic      iPin,
    output logic      tSeen
);
    // Timing stands still while run is low, 125 ns period while it is high
    initial
    begin
        sPin = 1'b0;
        rPin = 1'b1;
        iPin = 1'b1;
        tSeen = 1'b0;
        forever
        begin
            wait (run);
            #62.5 sPin = 1'b1;
            rPin = rNext;
            iPin = iNext;
            #62.5 sPin = 1'b0;
            tSeen = tPin;
        end
    end
endmodule : xdci_dce_model

/* tb/test_x21_dte_circuit_interface.sv */
// Self-checking bench for the X.21 line-side block
`timescale 1ns/1ps
`include "xdci_regs.svh"
module test_x21_dte_circuit_interface;
    logic clk_sys, rst_n, txBit, controlState, diagTest, openCmd;
    logic paramWriteCmd, strap, run, rNext, iNext, sPin, rPin, iPin;
    logic tSeen, txTaken, rxBit, rxValid, indicationState;
    logic indicationChange, prevI, es;
    logic [1:0] txQ[$], rxQ[$], vt, vr;
    logic [31:0] rnd;
    int err_total, checks_done, n, k;
    xdci_pkg::xdci_line_in_type lineIn;
    xdci_pkg::xdci_line_out_type lineOut;
    xdci_pkg::xdci_if_type ifSelect;
    assign lineIn = {rPin, iPin, sPin, strap};
    xdci_dte_line dut (.clk_sys(clk_sys), .rst_n(rst_n), .lineIn(lineIn),
        .lineOut(lineOut), .txBit(txBit), .controlState(controlState),
        .diagTest(diagTest), .txTaken(txTaken), .rxBit(rxBit),
        .rxValid(rxValid), .indicationState(indicationState),
        .indicationChange(indicationChange), .openCmd(openCmd),
        .paramWriteCmd(paramWriteCmd), .ifSelect(ifSelect));
    xdci_dce_model dce (.run(run), .rNext(rNext), .iNext(iNext),
        .tPin(lineOut.transmit), .sPin(sPin), .rPin(rPin), .iPin(iPin),
        .tSeen(tSeen));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input string nm, input logic seen, input logic ex);
        checks_done++;
        if (seen !== ex)
        begin
            err_total++;
            $display("[FAIL] %s exp %b seen %b", nm, ex, seen);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic sense(input logic s, o, p, input xdci_pkg::xdci_if_type e);
        @(posedge clk_sys);
        #1 strap = s;
        repeat (4) @(posedge clk_sys);
        #1 openCmd = o;
        paramWriteCmd = p;
        @(posedge clk_sys);
        #1 openCmd = 1'b0;
        paramWriteCmd = 1'b0;
        @(posedge clk_sys);
        #1 chk("ifSelect", ifSelect == e, 1'b1);
    endtask : sense
    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Next element noted when taken, then a fresh random one offered
    always @(posedge clk_sys)
        if (txTaken === 1'b1)
        begin
            txQ.push_back({txBit, controlState});
            #1 rnd = xs(rnd);
            txBit = rnd[0];
            controlState = rnd[1];
        end
    // Far side sample of T and C level at timing fall
    always @(negedge sPin)
        if (txQ.size() > 0)
        begin
            #1 vt = txQ.pop_front();
            chk("transmit", tSeen, vt[1]);
            chk("control", lineOut.control, vt[0]);
        end
    // T may only move while timing is on, just after its rise
    always @(lineOut.transmit)
        if (rst_n === 1'b1)
            chk("txEdge", sPin, 1'b1);
    // Note R and I placed by the DCE, then pick the next ones
    always @(posedge sPin)
    begin
        rxQ.push_back({rNext, iNext});
        #20 rnd = xs(rnd);
        rNext = rnd[2];
        iNext = rnd[3];
    end
    // Received element and indication tracking
    always @(posedge clk_sys)
        if (rxValid === 1'b1 && rxQ.size() > 0)
        begin
            vr = rxQ.pop_front();
            chk("rxBit", rxBit, vr[1]);
            chk("indicationState", indicationState, vr[0]);
            chk("indicationChange", indicationChange, vr[0] ^ prevI);
            prevI = vr[0];
        end
    // Main sequence
    initial
    begin
        {txBit, controlState, iNext, prevI} = 4'hf;
        {rst_n, diagTest, openCmd, paramWriteCmd, strap, run, rNext} = 7'h04;
        rnd = 32'h00006018;
        repeat (20) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 chk("resetSense", ifSelect == xdci_pkg::XDCI_IF_X21, 1'b1);
        chk("txIdle", lineOut.transmit, `XDCI_TXD_RESET);
        run = 1'b1;
        for (n = 0; n < 20000 && checks_done < 150; n++)
            @(posedge clk_sys);
        if (checks_done < 150)
            err_total++;
        run = 1'b0;
        #1 diagTest = 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("extTimingOe", lineOut.extTimingOe, 1'b1);
        es = lineOut.extTiming;
        k = 0;
        repeat (64)
        begin
            @(posedge clk_sys);
            if (lineOut.extTiming !== es)
                k++;
            es = lineOut.extTiming;
        end
        chk("esToggles", k == 64 / `XDCI_ES_HALF_CYC, 1'b1);
        sense(1'b1, 1'b1, 1'b0, xdci_pkg::XDCI_IF_X21);
        sense(1'b0, 1'b0, 1'b1, xdci_pkg::XDCI_IF_EIA);
        sense(1'b1, 1'b0, 1'b0, xdci_pkg::XDCI_IF_EIA);
        sense(1'b1, 1'b0, 1'b1, xdci_pkg::XDCI_IF_X21);
        finish_test();
    end
endmodule : test_x21_dte_circuit_interface
